// ===== step_gen_top.sv
// step_gen_top: stepper pulse generator with watchdog, reset paths and quadrature count
// assumes an APB master on clk; jumper and encoder pins are asynchronous and synchronised here
`timescale 1ns/10ps
`default_nettype none
module step_gen_top (
  input wire logic clk, // 50 MHz system clock
  input wire logic sys_rst, // synchronous reset, active high (power-up)
  input wire logic ce, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic watchdogEnableJumper, // jumper fitted enables watchdog
  input wire logic quadA, // encoder channel a
  input wire logic quadB, // encoder channel b
  output logic stepPulse_n, // low-going step pulse
  output logic stepDir, // direction, high for plus
  output logic genIrq, // generator interrupt request (end of move)
  output logic watchdogTimeout_n // low after watchdog timeout
);
  // 1.5 s timeout; parameter so simulation can shorten it
  parameter int WD_CYCLES = step_gen_pkg::WD_CYCLES;

  logic [7:0] ctrlReg;
  step_gen_pkg::profile_t profReg;
  logic irqReg;
  logic wdTripReg;
  logic [26:0] wdCntReg;
  logic [15:0] countReg;
  logic [3:0] refCntReg;
  logic jmpS1Reg, jmpS2Reg;
  logic [1:0] qS1Reg, qS2Reg, qPrevReg;
  logic startReg, softRstReg, busRstReg;
  logic runPrevReg;
  logic running, stepOut;

  // apb decode
  wire logic access = psel && penable;
  wire logic wr = access && pwrite;
  wire logic hitCtrl = (paddr == step_gen_pkg::CTRL_OFF);
  wire logic hitHigh = (paddr == step_gen_pkg::HIGH_OFF);
  wire logic hitLow = (paddr == step_gen_pkg::LOW_OFF);
  wire logic hitRamp = (paddr == step_gen_pkg::RAMP_OFF);
  wire logic hitMult = (paddr == step_gen_pkg::MULT_OFF);
  wire logic hitCmd = (paddr == step_gen_pkg::CMD_OFF);
  wire logic hitWdog = (paddr == step_gen_pkg::WDOG_OFF);
  wire logic hitStat = (paddr == step_gen_pkg::STAT_OFF);
  wire logic hitCount = (paddr == step_gen_pkg::COUNT_OFF);
  wire logic mapped = hitCtrl | hitHigh | hitLow | hitRamp | hitMult | hitCmd | hitWdog | hitStat | hitCount;
  wire logic [1:0] cmdCode = pwdata[1:0];
  wire logic cmdWr = wr && hitCmd && mapped;
  wire logic wdHit = wr && hitWdog; // any write to the watchdog register services the watchdog

  // clamp writes into the legal ranges
  wire logic [12:0] spdIn = pwdata[12:0];
  wire logic [12:0] spdClamp = (spdIn < step_gen_pkg::SPEED_MIN) ? step_gen_pkg::SPEED_MIN : spdIn;
  wire logic [9:0] factIn = pwdata[9:0];
  wire logic [9:0] factClamp = (factIn < step_gen_pkg::FACT_MIN) ? step_gen_pkg::FACT_MIN : factIn;

  // generator reset: hard (control bit, power-up), watchdog, soft, bus reset strobe
  wire logic wdForce = wdTripReg && jmpS2Reg;
  wire logic hardRst = sys_rst || !ctrlReg[step_gen_pkg::CTRL_GEN_RST_BIT] || busRstReg;
  wire logic genRst = hardRst || wdForce || softRstReg;
  wire logic cntRst = sys_rst || !ctrlReg[step_gen_pkg::CTRL_CNT_RST_BIT] || busRstReg;

  // control register: only power-up resets it, bus reset leaves it alone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrlReg <= step_gen_pkg::CTRL_RESET;
    end else if (ce && wr && hitCtrl) begin
      ctrlReg <= pwdata[7:0];
    end
  end

  // settings survive soft reset and watchdog reset; only hard resets restore defaults
  always_ff @(posedge clk) begin
    if (hardRst) begin
      profReg <= '{high: step_gen_pkg::HIGH_RESET, low: step_gen_pkg::LOW_RESET,
                   ramp: step_gen_pkg::RAMP_RESET, mult: step_gen_pkg::MULT_RESET};
    end else if (ce && wr) begin
      if (hitHigh) profReg.high <= spdClamp;
      if (hitLow) profReg.low <= spdClamp;
      if (hitRamp) profReg.ramp <= factClamp;
      if (hitMult) profReg.mult <= factClamp;
    end
  end

  // command strobes, one cycle each
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      startReg <= 1'b0;
      softRstReg <= 1'b0;
      busRstReg <= 1'b0;
    end else if (ce) begin
      startReg <= cmdWr && (cmdCode == step_gen_pkg::CMD_START);
      softRstReg <= cmdWr && (cmdCode == step_gen_pkg::CMD_SOFT_RESET);
      busRstReg <= cmdWr && (cmdCode == step_gen_pkg::CMD_BUS_RESET);
    end
  end

  // watchdog: counts while the jumper is fitted; trip holds until serviced or the jumper is removed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdCntReg <= 27'h0000000;
      wdTripReg <= 1'b0;
    end else if (ce) begin
      if (wdHit || !jmpS2Reg) begin
        wdCntReg <= 27'h0000000;
        wdTripReg <= 1'b0;
      end else if (wdCntReg >= 27'(WD_CYCLES - 1)) begin
        wdTripReg <= 1'b1;
      end else begin
        wdCntReg <= wdCntReg + 27'h0000001;
      end
    end
  end

  // interrupt request: set at end of move; a soft-reset clear wins, since a set is blocked while genRst is high
  always_ff @(posedge clk) begin
    if (hardRst) begin
      irqReg <= 1'b0;
      runPrevReg <= 1'b0;
    end else if (ce) begin
      // a move cut by any generator reset is not an end of move, so it must not raise the request
      runPrevReg <= running && !genRst;
      if (runPrevReg && !running && !genRst) begin
        irqReg <= 1'b1;
      end else if (softRstReg || wdForce) begin
        irqReg <= 1'b0;
      end
    end
  end

  // reference tick: 6 MHz derived from the 50 MHz clock (integer divide, slightly fast)
  wire logic refTick = (refCntReg == 4'(step_gen_pkg::REF_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refCntReg <= 4'h0;
    end else if (ce) begin
      refCntReg <= refTick ? 4'h0 : refCntReg + 4'h1;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      jmpS1Reg <= 1'b0;
      jmpS2Reg <= 1'b0;
      qS1Reg <= 2'h0;
      qS2Reg <= 2'h0;
    end else if (ce) begin
      jmpS1Reg <= watchdogEnableJumper;
      jmpS2Reg <= jmpS1Reg;
      qS1Reg <= {quadA, quadB};
      qS2Reg <= qS1Reg;
    end
  end

  // quadrature count: own reset, power-up, count-reset control bit and bus reset only, never touched by the watchdog
  wire logic qMoved = (qS2Reg != qPrevReg);
  wire logic qUp = (qPrevReg[1] ^ qS2Reg[0]);
  always_ff @(posedge clk) begin
    if (cntRst) begin
      countReg <= 16'h0000;
      qPrevReg <= qS2Reg;
    end else if (ce) begin
      qPrevReg <= qS2Reg;
      if (qMoved && (qPrevReg[0] ^ qPrevReg[1]) != (qS2Reg[0] ^ qS2Reg[1])) begin
        countReg <= qUp ? countReg + 16'h0001 : countReg - 16'h0001;
      end
    end
  end

  // read mux
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h00000000;
    if (hitCtrl) rdata = {24'h000000, ctrlReg};
    if (hitHigh) rdata = {19'h00000, profReg.high};
    if (hitLow) rdata = {19'h00000, profReg.low};
    if (hitRamp) rdata = {22'h000000, profReg.ramp};
    if (hitMult) rdata = {22'h000000, profReg.mult};
    if (hitStat) rdata = {28'h0000000, jmpS2Reg, wdTripReg, irqReg, running};
    if (hitCount) rdata = {16'h0000, countReg};
  end

  // read data registered at the setup edge, ahead of the access phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= rdata;
    end
  end

  assign pready = 1'b1; // zero-wait slave
  assign pslverr = access && !mapped;

  step_rate_core rateCore (
    .clk(clk),
    .ce(ce),
    .genRst(genRst),
    .refTick(refTick),
    .start(startReg),
    .highMode(ctrlReg[step_gen_pkg::CTRL_HIGH_MODE_BIT]),
    .prof(profReg),
    .running(running),
    .stepOut(stepOut)
  );

  assign stepPulse_n = !stepOut;
  assign stepDir = ctrlReg[step_gen_pkg::CTRL_DIR_BIT];
  assign genIrq = irqReg;
  assign watchdogTimeout_n = !wdForce;
endmodule
`default_nettype wire

// ===== step_gen_pkg.sv
// step_gen_pkg: constants, register map and carrier types for the stepper pulse generator
// assumes a 50 MHz system clock and an APB master with 32-bit data
package step_gen_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] HIGH_OFF = 8'h04;
  localparam logic [7:0] LOW_OFF = 8'h08;
  localparam logic [7:0] RAMP_OFF = 8'h0C;
  localparam logic [7:0] MULT_OFF = 8'h10;
  localparam logic [7:0] CMD_OFF = 8'h14;
  localparam logic [7:0] WDOG_OFF = 8'h18;
  localparam logic [7:0] STAT_OFF = 8'h1C;
  localparam logic [7:0] COUNT_OFF = 8'h20;

  // control register fields
  localparam int CTRL_CNT_RST_BIT = 0;
  localparam int CTRL_GEN_RST_BIT = 1;
  localparam int CTRL_HIGH_MODE_BIT = 2;
  localparam int CTRL_DIR_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h03;

  // command register codes
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_SOFT_RESET = 2'h2;
  localparam logic [1:0] CMD_BUS_RESET = 2'h3;

  // status fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  localparam int STAT_WD_TRIP_BIT = 2;
  localparam int STAT_JUMPER_BIT = 3;

  // setting ranges and reset values
  localparam logic [12:0] SPEED_MIN = 13'h0001;
  localparam logic [12:0] SPEED_MAX = 13'h1FFF;
  localparam logic [9:0] FACT_MIN = 10'h002;
  localparam logic [9:0] FACT_MAX = 10'h3FF;
  localparam logic [12:0] HIGH_RESET = 13'h0064;
  localparam logic [12:0] LOW_RESET = 13'h000A;
  localparam logic [9:0] RAMP_RESET = 10'h064;
  localparam logic [9:0] MULT_RESET = 10'h2DC;
  localparam logic [12:0] ACC_MOD = 13'h1FFF; // speed accumulator wraps at 8192

  // timing
  localparam int CLK_HZ = 50000000;
  localparam int REF_HZ = 6000000;
  localparam int REF_CYCLES = CLK_HZ / REF_HZ; // 8 sys clocks per reference tick (8.33, rounded down)
  localparam int WD_TIMEOUT_MS = 1500;
  localparam int WD_CYCLES = (CLK_HZ / 1000) * WD_TIMEOUT_MS;
  localparam int PULSE_LOW_CYCLES = 4; // width of the low-going step pulse

  // speed profile handed to the divider
  typedef struct packed {
    logic [12:0] high;
    logic [12:0] low;
    logic [9:0] ramp;
    logic [9:0] mult;
  } profile_t;

endpackage

// ===== step_rate_core.sv
// step_rate_core: ramped variable divider that makes the step pulse train
// assumes a one-cycle reference tick at 6 MHz and settings already range-clamped
`timescale 1ns/10ps
`default_nettype none
module step_rate_core (
  input wire logic clk, // system clock
  input wire logic ce, // clock enable, freezes all state except under genRst
  input wire logic genRst, // combined hard/soft reset of the generator
  input wire logic refTick, // one pulse per reference period
  input wire logic start, // start a move
  input wire logic highMode, // ramp up from low to high speed
  input wire step_gen_pkg::profile_t prof, // speed profile
  output logic running, // move in progress
  output logic stepOut // step pulse, active high internally
);
  typedef enum logic [1:0] {IDLE = 2'b01, RUN = 2'b10} core_state_t;
  core_state_t stateReg, stateNext;
  logic [12:0] speedReg, speedNext;
  logic [9:0] rampCntReg, rampCntNext;
  logic [9:0] multCntReg, multCntNext;
  logic [13:0] accReg, accNext;
  logic [2:0] pulseCntReg, pulseCntNext;
  wire logic multWrap = (multCntReg >= prof.mult - 10'h001);
  wire logic rampWrap = (rampCntReg >= prof.ramp - 10'h001);
  wire logic [13:0] accSum = accReg + {1'b0, speedReg};
  wire logic accOver = accSum > {1'b0, step_gen_pkg::ACC_MOD};
  wire logic [12:0] target = highMode ? prof.high : prof.low;

  // next-state: divide ref by mult, accumulate speed/8192, step speed once per ramp periods
  always_comb begin
    stateNext = stateReg;
    speedNext = speedReg;
    rampCntNext = rampCntReg;
    multCntNext = multCntReg;
    accNext = accReg;
    pulseCntNext = (pulseCntReg != 3'h0) ? pulseCntReg - 3'h1 : 3'h0;
    case (stateReg)
      IDLE: begin
        if (start) begin
          stateNext = RUN;
          speedNext = prof.low;
          accNext = 14'h0000;
          multCntNext = 10'h000;
          rampCntNext = 10'h000;
        end
      end
      RUN: begin
        if (refTick) begin
          // ramp: one speed unit per ramp ticks gives accel = ref/ramp
          rampCntNext = rampWrap ? 10'h000 : rampCntReg + 10'h001;
          if (rampWrap && speedReg < target) begin
            speedNext = speedReg + 13'h0001;
          end else if (rampWrap && speedReg > target) begin
            speedNext = speedReg - 13'h0001;
          end
          // divider then multiplier stage: f = speed/8192 * ref/mult
          multCntNext = multWrap ? 10'h000 : multCntReg + 10'h001;
          if (multWrap) begin
            accNext = accOver ? accSum - 14'h2000 : accSum;
            if (accOver) begin
              pulseCntNext = 3'(step_gen_pkg::PULSE_LOW_CYCLES);
            end
          end
        end
      end
      default: stateNext = IDLE;
    endcase
  end

  // state registers; generator reset stops the train at once
  always_ff @(posedge clk) begin
    if (genRst) begin
      stateReg <= IDLE;
      speedReg <= 13'h0000;
      rampCntReg <= 10'h000;
      multCntReg <= 10'h000;
      accReg <= 14'h0000;
      pulseCntReg <= 3'h0;
    end else if (ce) begin
      stateReg <= stateNext;
      speedReg <= speedNext;
      rampCntReg <= rampCntNext;
      multCntReg <= multCntNext;
      accReg <= accNext;
      pulseCntReg <= pulseCntNext;
    end
  end

  assign running = (stateReg == RUN);
  assign stepOut = (pulseCntReg != 3'h0);
endmodule
`default_nettype wire

// ===== step_gen_props.sv
// step_gen_props: port-level checks on the pulse generator top
// assumes it is bound into step_gen_top and sees its ports only
`timescale 1ns/10ps
`default_nettype none
module step_gen_props #(parameter int WD_CYCLES = 1000) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic watchdogEnableJumper, // jumper level
  input wire logic stepPulse_n, // step pulse
  input wire logic genIrq, // interrupt request
  input wire logic watchdogTimeout_n // watchdog output
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // access-phase decodes; writes land on these edges
  wire wrAcc = psel && penable && pwrite;
  wire rdAcc = psel && penable && !pwrite;
  wire cmdWr = wrAcc && paddr == step_gen_pkg::CMD_OFF;
  wire kick = wrAcc && paddr == step_gen_pkg::WDOG_OFF;

  // one cycle of slack lets a pulse already under way be cut by the reset
  trip_no_steps_a: assert property ((!watchdogTimeout_n)[*2] |-> stepPulse_n)
    else $error("step pulse while watchdog holds reset");
  trip_holds_a: assert property (!watchdogTimeout_n && !kick && watchdogEnableJumper |=> !watchdogTimeout_n)
    else $error("watchdog released without service");
  no_jumper_a: assert property ((!watchdogEnableJumper)[*4] |-> watchdogTimeout_n)
    else $error("watchdog timeout without jumper");
  soft_stop_a: assert property (cmdWr && pwdata[1:0] == step_gen_pkg::CMD_SOFT_RESET
    |-> ##2 (stepPulse_n && !genIrq)[*8])
    else $error("soft reset left pulses or irq");
  hard_stop_a: assert property (wrAcc && paddr == step_gen_pkg::CTRL_OFF && !pwdata[1]
    |-> ##2 stepPulse_n[*8])
    else $error("generator reset bit did not stop pulses");
  bus_stop_a: assert property (cmdWr && pwdata[1:0] == step_gen_pkg::CMD_BUS_RESET |-> ##2 stepPulse_n[*8])
    else $error("bus reset did not stop pulses");
  mult_range_a: assert property (rdAcc && paddr == step_gen_pkg::MULT_OFF
    |-> prdata[9:0] >= step_gen_pkg::FACT_MIN && prdata[31:10] == 22'h0)
    else $error("multiplier read out of range");
  ramp_range_a: assert property (rdAcc && paddr == step_gen_pkg::RAMP_OFF
    |-> prdata[9:0] >= step_gen_pkg::FACT_MIN && prdata[31:10] == 22'h0)
    else $error("ramp read out of range");
  speed_range_a: assert property (rdAcc && (paddr == step_gen_pkg::HIGH_OFF || paddr == step_gen_pkg::LOW_OFF)
    |-> prdata[12:0] >= step_gen_pkg::SPEED_MIN && prdata[31:13] == 19'h0)
    else $error("speed read out of range");
endmodule
bind step_gen_top step_gen_props #(.WD_CYCLES(WD_CYCLES)) u_props (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .watchdogEnableJumper(watchdogEnableJumper), .stepPulse_n(stepPulse_n), .genIrq(genIrq),
  .watchdogTimeout_n(watchdogTimeout_n));
`default_nettype wire

// ===== step_motor_model.sv
// step_motor_model: motor driver with shaft encoder, fed by the step outputs
// assumes low-going step pulses of at least one clock
`timescale 1ns/10ps
`default_nettype none
module step_motor_model (
  input wire logic clk, // system clock
  input wire logic stepPulse_n, // step pulse
  input wire logic stepDir, // direction, high for plus
  output logic quadA, // encoder channel a
  output logic quadB, // encoder channel b
  output int stepCount, // steps seen
  output int lastGap // clocks between the last two steps
);
  int cyc;
  int lastFall;
  bit prevLvl;
  bit [1:0] phase;
  // gray code from the shaft phase; the shaft holds still between steps
  assign quadA = phase[1];
  assign quadB = phase[1] ^ phase[0];
  // one encoder state per step, in the commanded direction
  always @(posedge clk) begin
    cyc++;
    if (prevLvl && stepPulse_n === 1'b0) begin
      stepCount++;
      lastGap = cyc - lastFall;
      lastFall = cyc;
      phase <= stepDir ? phase + 2'h1 : phase - 2'h1;
    end
    prevLvl = stepPulse_n;
  end
endmodule
`default_nettype wire

// ===== stepper_pulse_gen_reset_watchdog_tb.sv
// stepper_pulse_gen_reset_watchdog_tb: self-checking bench for step_gen_top
// assumes an apb host here and a motor model on the step outputs
`timescale 1ns/10ps
`default_nettype none
module stepper_pulse_gen_reset_watchdog_tb;
  typedef struct packed {
    logic [12:0] hs;
    logic [12:0] ls;
    logic [9:0] mult;
    logic mode;
    logic dir;
    logic [31:0] gap;
  } row_t;
  // gap is REF_CYCLES * mult * 8192 / speed clocks
  row_t rows [4] = '{'{13'h1000, 13'h1000, 10'h002, 1'b0, 1'b0, 32'h20},
    '{13'h0800, 13'h0800, 10'h003, 1'b0, 1'b1, 32'h60}, '{13'h0400, 13'h0400, 10'h005, 1'b0, 1'b0, 32'h140},
    '{13'h1FFF, 13'h0800, 10'h002, 1'b1, 1'b1, 32'h40}};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic watchdogEnableJumper = 1'b0;
  logic [31:0] prdata, rd, c1;
  logic pready, pslverr, err, quadA, quadB, stepPulse_n, stepDir, genIrq, watchdogTimeout_n;
  int stepCount, lastGap, s0, errors, n_compared;

  always #10 clk = ~clk;

  step_gen_top #(.WD_CYCLES(1000)) u_dut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .watchdogEnableJumper(watchdogEnableJumper), .quadA(quadA), .quadB(quadB), .stepPulse_n(stepPulse_n),
    .stepDir(stepDir), .genIrq(genIrq), .watchdogTimeout_n(watchdogTimeout_n));
  step_motor_model u_motor (.clk(clk), .stepPulse_n(stepPulse_n), .stepDir(stepDir), .quadA(quadA), .quadB(quadB),
    .stepCount(stepCount), .lastGap(lastGap));

  task close_out;
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task give_up;
    errors++;
    close_out();
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) give_up();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check("readback", rd, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic waitSteps(input int n);
    s0 = stepCount;
    for (int k = 0; k < 4000; k++) begin
      @(negedge clk);
      if (stepCount >= s0 + n) return;
    end
    give_up();
  endtask
  task automatic halted(input int n);
    s0 = stepCount;
    idle(n);
    check("steps", stepCount, s0);
  endtask
  task automatic fast;
    wr(step_gen_pkg::LOW_OFF, 32'h1000);
    wr(step_gen_pkg::HIGH_OFF, 32'h1000);
    wr(step_gen_pkg::MULT_OFF, 32'h2);
  endtask

  // main sequence: reset, profile rows, then reset paths and watchdog
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    idle(2);
    check("pulse", stepPulse_n, 1'b1);
    check("wdo", watchdogTimeout_n, 1'b1);
    rdChk(step_gen_pkg::COUNT_OFF, 32'h0);
    foreach (rows[i]) begin
      wr(step_gen_pkg::HIGH_OFF, 32'(rows[i].hs));
      wr(step_gen_pkg::LOW_OFF, 32'(rows[i].ls));
      wr(step_gen_pkg::RAMP_OFF, 32'h3FF);
      wr(step_gen_pkg::MULT_OFF, 32'(rows[i].mult));
      wr(step_gen_pkg::CTRL_OFF, {28'h0, rows[i].dir, rows[i].mode, 2'h3});
      wr(step_gen_pkg::CMD_OFF, 32'(step_gen_pkg::CMD_START));
      waitSteps(3);
      check("gap", lastGap, rows[i].gap);
      check("dir", stepDir, rows[i].dir);
      wr(step_gen_pkg::CMD_OFF, 32'(step_gen_pkg::CMD_SOFT_RESET));
      halted(200);
      rdChk(step_gen_pkg::HIGH_OFF, 32'(rows[i].hs));
    end
    wr(step_gen_pkg::MULT_OFF, 32'h0);
    rdChk(step_gen_pkg::MULT_OFF, 32'(step_gen_pkg::FACT_MIN));
    wr(step_gen_pkg::RAMP_OFF, 32'h1);
    rdChk(step_gen_pkg::RAMP_OFF, 32'(step_gen_pkg::FACT_MIN));
    wr(step_gen_pkg::HIGH_OFF, 32'h0);
    rdChk(step_gen_pkg::HIGH_OFF, 32'(step_gen_pkg::SPEED_MIN));
    wr(step_gen_pkg::LOW_OFF, 32'h1FFF);
    rdChk(step_gen_pkg::LOW_OFF, 32'(step_gen_pkg::SPEED_MAX));
    // hard reset through the control bits
    fast();
    wr(step_gen_pkg::CMD_OFF, 32'(step_gen_pkg::CMD_START));
    waitSteps(2);
    wr(step_gen_pkg::CTRL_OFF, 32'h1);
    halted(200);
    rdChk(step_gen_pkg::HIGH_OFF, 32'(step_gen_pkg::HIGH_RESET));
    rdChk(step_gen_pkg::MULT_OFF, 32'h2DC);
    wr(step_gen_pkg::CTRL_OFF, 32'h2);
    rdChk(step_gen_pkg::COUNT_OFF, 32'h0);
    // bus reset spares the control register
    wr(step_gen_pkg::CTRL_OFF, 32'hB);
    fast();
    wr(step_gen_pkg::CMD_OFF, 32'(step_gen_pkg::CMD_START));
    waitSteps(4);
    wr(step_gen_pkg::CMD_OFF, 32'(step_gen_pkg::CMD_BUS_RESET));
    halted(200);
    rdChk(step_gen_pkg::COUNT_OFF, 32'h0);
    rdChk(step_gen_pkg::CTRL_OFF, 32'hB);
    // watchdog serviced in time, then left to expire
    @(posedge clk);
    watchdogEnableJumper <= 1'b1;
    wr(step_gen_pkg::WDOG_OFF, 32'h0);
    fast();
    wr(step_gen_pkg::CMD_OFF, 32'(step_gen_pkg::CMD_START));
    repeat (4) begin
      idle(500);
      wr(step_gen_pkg::WDOG_OFF, 32'h0);
    end
    idle(2);
    check("wdo", watchdogTimeout_n, 1'b1);
    idle(1300);
    check("wdo", watchdogTimeout_n, 1'b0);
    apb(step_gen_pkg::STAT_OFF, 1'b0, 32'h0);
    check("trip", rd[step_gen_pkg::STAT_WD_TRIP_BIT], 1'b1);
    apb(step_gen_pkg::COUNT_OFF, 1'b0, 32'h0);
    c1 = rd;
    halted(300);
    apb(step_gen_pkg::COUNT_OFF, 1'b0, 32'h0);
    check("count", rd, c1);
    check("moved", c1 !== 32'h0, 1'b1);
    check("wdo", watchdogTimeout_n, 1'b0);
    wr(step_gen_pkg::WDOG_OFF, 32'h0);
    idle(2);
    check("wdo", watchdogTimeout_n, 1'b1);
    wr(step_gen_pkg::CMD_OFF, 32'(step_gen_pkg::CMD_START));
    waitSteps(2);
    // jumper removed: no timeout however long
    @(posedge clk);
    watchdogEnableJumper <= 1'b0;
    idle(2500);
    check("wdo", watchdogTimeout_n, 1'b1);
    s0 = stepCount;
    idle(100);
    check("running", stepCount > s0, 1'b1);
    apb(8'h40, 1'b0, 32'h0);
    check("slverr", err, 1'b1);
    check("rdata", rd, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
